// ===== include/ssc_pkg.sv
// Package of the converter's serial configuration register bank.
// Assumes one system clock; the serial pins are sampled as synchronous inputs.
package ssc_pkg;

  // ----------------------------------------
  // Serial frame layout
  // ----------------------------------------
  localparam int SSC_ADDR_W = 15;
  localparam int SSC_INSTR_BITS = 16;
  localparam int SSC_DATA_BITS = 8;
  localparam int SSC_RW_POS = 15;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [14:0] SSC_OFS_CONFIG = 15'h0000;
  localparam logic [14:0] SSC_OFS_USER_SPI = 15'h0010;
  localparam logic [14:0] SSC_OFS_CLK0 = 15'h0029;
  localparam logic [14:0] SSC_OFS_CLK1 = 15'h002A;
  localparam logic [14:0] SSC_OFS_CLK2 = 15'h002B;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] SSC_RST_CONFIG = 8'h30;
  localparam logic [7:0] SSC_RST_USER_SPI = 8'h00;
  localparam logic [7:0] SSC_RST_CLK0 = 8'h00;
  localparam logic [7:0] SSC_RST_CLK1 = 8'h00;
  localparam logic [7:0] SSC_RST_CLK2 = 8'h11;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int SSC_CFG_SOFT_RESET = 7;
  localparam int SSC_CFG_ASCEND = 5;
  localparam int SSC_CFG_SDO_ACTIVE = 4;
  localparam int SSC_USR_ADDR_HOLD = 0;
  localparam int SSC_CK0_PROC_ON = 6;
  localparam int SSC_CK0_RECV_ON = 5;
  localparam int SSC_CK0_FINE = 4;
  localparam int SSC_CK0_SEL_HI = 3;
  localparam int SSC_CK0_SEL_LO = 0;
  localparam int SSC_CK1_MARKER = 3;
  localparam int SSC_CK1_DEVCLK_PECL = 2;
  localparam int SSC_CK1_SYSREF_PECL = 1;
  localparam int SSC_CK1_FLIP = 0;
  localparam int SSC_CK2_FB_GAIN = 4;
  localparam int SSC_CK2_NOISE = 2;
  localparam int SSC_CK2_DEL_HI = 1;
  localparam int SSC_CK2_DEL_LO = 0;

  // ----------------------------------------
  // Alignment path
  // ----------------------------------------
  localparam int SSC_TAP_W = 4;
  localparam int SSC_DELAY_DEPTH = 32;
  localparam int SSC_SAMPLE_W = 12;

  typedef enum logic [0:0] {
    SSC_INSTR,
    SSC_DATA
  } ssc_phase_t;

endpackage

// ===== include/ssc_sysref_if.sv
// Carrier between the register bank and its SYSREF delay line.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface ssc_sysref_if;
  import ssc_pkg::*;
  logic raw;
  logic fine_window;
  logic [SSC_TAP_W-1:0] delay_choice;
  logic aligned;
  modport bank (output raw, output fine_window, output delay_choice, input aligned);
  modport line (input raw, input fine_window, input delay_choice, output aligned);
endinterface

// ===== rtl/ssc_sysref_delay.sv
// SYSREF tapped delay line with selectable tap and step size.
// Assumes the bank drives the received, polarity-corrected level.
`timescale 1ns/1ps
module ssc_sysref_delay
  import ssc_pkg::*;
#(
  parameter int DEPTH = SSC_DELAY_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // Bank side
  ssc_sysref_if.line sr
);

  typedef struct packed {
    logic [DEPTH-1:0] taps;
    logic aligned;
  } ssc_dl_state_t;

  ssc_dl_state_t st;
  ssc_dl_state_t next_st;
  logic [4:0] tap_idx;

  // ----------------------------------------
  // Tap selection
  // ----------------------------------------
  // Fine window halves the step between selectable taps
  always_comb begin
    tap_idx = sr.fine_window ? {1'h0, sr.delay_choice} : {sr.delay_choice, 1'h0};
    next_st = st;
    next_st.taps = {st.taps[DEPTH-2:0], sr.raw};
    next_st.aligned = st.taps[tap_idx];
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign sr.aligned = st.aligned;

endmodule // ssc_sysref_delay

// ===== rtl/ssc_cfg_regs.sv
// Serial configuration registers: streaming address control, SYSREF path, sampling clock.
// Assumes the serial pins are synchronous to clk and clk is well above the serial rate.
`timescale 1ns/1ps

// Function
// - Address freeze bit holds the address for every streamed byte.
// - Freeze bit clear (reset) lets the address step in chosen direction.
// - Direction bit, reset one, increments; cleared, decrements the address.
// - Processor bit 6 gates SYSREF event handling; resets disabled.
// - Receiver bit 5 enables SYSREF input; resets disabled, input ignored.
// - Fine window bit 4 selects smaller SYSREF delay steps.
// - Four-bit delay choice selects applied SYSREF tap; resets zero.
// - Marker inject plus sample marker enable puts SYSREF on sample LSB.
// - Marker injection works only with decimation bypassed.
// - Second control bit 0 inverts SYSREF polarity; resets zero.
// - Second control bit 2 puts device clock input in PECL mode.
// - Second control bit 1 puts SYSREF input in PECL mode.
// - Third control bits 1:0 one-hot sampling delay; resets 0x1.
// - Third control bit 2 enables supply noise suppression.
// - Third control bit 4 sets clock converter feedback gain; resets one.
module ssc_cfg_regs
  import ssc_pkg::*;
#(
  parameter int SAMPLE_W = SSC_SAMPLE_W,
  parameter int DELAY_DEPTH = SSC_DELAY_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // Serial configuration port
  input wire logic spi_cs_n,
  input wire logic spi_sclk,
  input wire logic spi_sdi,
  output logic spi_sdo,
  output logic spi_sdo_oe_n,
  // SYSREF path
  input wire logic sysref_in,
  output logic sysref_event,
  // Sample marking
  input wire logic sample_marker_on,
  input wire logic decimation_bypass,
  input wire logic [SAMPLE_W-1:0] sample_in,
  output logic [SAMPLE_W-1:0] sample_out,
  // Configuration outputs
  output logic sysref_processor_on,
  output logic sysref_receiver_on,
  output logic sysref_fine_window,
  output logic [SSC_TAP_W-1:0] sysref_delay_choice,
  output logic sysref_marker_inject,
  output logic device_clock_pecl_mode,
  output logic sysref_pecl_mode,
  output logic sysref_polarity_flip,
  output logic supply_noise_suppress,
  output logic [1:0] sampling_clock_delay,
  output logic clock_feedback_gain
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    ssc_phase_t phase;
    logic sclk_q;
    logic [4:0] bit_cnt;
    logic [SSC_INSTR_BITS-1:0] shift_in;
    logic rd;
    logic [SSC_ADDR_W-1:0] addr;
    logic [7:0] rd_shift;
    logic sdo;
    logic sdo_oe_n;
    logic [7:0] config_reg;
    logic [7:0] user_spi_config;
    logic [7:0] clock_control_0;
    logic [7:0] clock_control_1;
    logic [7:0] clock_control_2;
    logic aligned_q;
    logic sysref_event;
    logic [SAMPLE_W-1:0] sample_out;
  } ssc_state_t;

  localparam ssc_state_t SSC_RESET_STATE = '{
    phase: SSC_INSTR,
    sclk_q: 1'b0,
    bit_cnt: 5'h00,
    shift_in: '0,
    rd: 1'b0,
    addr: '0,
    rd_shift: 8'h00,
    sdo: 1'b0,
    sdo_oe_n: 1'b1,
    config_reg: SSC_RST_CONFIG,
    user_spi_config: SSC_RST_USER_SPI,
    clock_control_0: SSC_RST_CLK0,
    clock_control_1: SSC_RST_CLK1,
    clock_control_2: SSC_RST_CLK2,
    aligned_q: 1'b0,
    sysref_event: 1'b0,
    sample_out: '0
  };

  ssc_state_t st;
  ssc_state_t next_st;
  logic sclk_rise;
  logic sclk_fall;
  logic [7:0] wr_byte;
  logic [SSC_ADDR_W-1:0] instr_addr;
  logic [SSC_ADDR_W-1:0] step_addr;
  logic marker_live;

  ssc_sysref_if sr_if ();

  // ----------------------------------------
  // Register read mux
  // ----------------------------------------
  // Soft reset reads back as zero since it clears itself; output enable is fixed at one.
  function automatic logic [7:0] read_reg(input ssc_state_t s, input logic [SSC_ADDR_W-1:0] a);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      SSC_OFS_CONFIG: begin
        v = s.config_reg;
        v[SSC_CFG_SOFT_RESET] = 1'b0;
        v[SSC_CFG_SDO_ACTIVE] = 1'b1;
      end
      SSC_OFS_USER_SPI: v = s.user_spi_config;
      SSC_OFS_CLK0: v = s.clock_control_0;
      SSC_OFS_CLK1: v = s.clock_control_1;
      SSC_OFS_CLK2: v = s.clock_control_2;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // ----------------------------------------
  // Streaming address step
  // ----------------------------------------
  function automatic logic [SSC_ADDR_W-1:0] next_addr(input ssc_state_t s, input logic [SSC_ADDR_W-1:0] a);
    logic [SSC_ADDR_W-1:0] r;
    r = a;
    if (s.user_spi_config[SSC_USR_ADDR_HOLD]) begin
      r = a;
    end else if (s.config_reg[SSC_CFG_ASCEND]) begin
      r = a + 15'h0001;
    end else begin
      r = a - 15'h0001;
    end
    return r;
  endfunction

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    next_st = st;
    sclk_rise = !spi_cs_n && spi_sclk && !st.sclk_q;
    sclk_fall = !spi_cs_n && !spi_sclk && st.sclk_q;
    wr_byte = {st.shift_in[6:0], spi_sdi};
    instr_addr = {st.shift_in[SSC_ADDR_W-2:0], spi_sdi};
    step_addr = next_addr(st, st.addr);
    marker_live = st.clock_control_1[SSC_CK1_MARKER] && sample_marker_on && decimation_bypass;
    next_st.sclk_q = spi_sclk;

    // Serial frame
    if (spi_cs_n) begin
      // Deselect aborts any half byte; a partial write never lands
      next_st.phase = SSC_INSTR;
      next_st.bit_cnt = 5'h00;
      next_st.sdo_oe_n = 1'b1;
      next_st.sdo = 1'b0;
    end else if (sclk_rise) begin
      next_st.shift_in = {st.shift_in[SSC_INSTR_BITS-2:0], spi_sdi};
      next_st.bit_cnt = st.bit_cnt + 5'h01;
      unique case (st.phase)
        SSC_INSTR: begin
          if (st.bit_cnt == 5'(SSC_INSTR_BITS - 1)) begin
            next_st.rd = st.shift_in[SSC_RW_POS-1];
            next_st.addr = instr_addr;
            next_st.phase = SSC_DATA;
            next_st.bit_cnt = 5'h00;
            next_st.rd_shift = read_reg(st, instr_addr);
          end
        end
        SSC_DATA: begin
          if (st.bit_cnt == 5'(SSC_DATA_BITS - 1)) begin
            next_st.bit_cnt = 5'h00;
            next_st.addr = step_addr;
            if (st.rd) begin
              next_st.rd_shift = read_reg(st, step_addr);
            end else begin
              unique case (st.addr)
                SSC_OFS_CONFIG: begin
                  next_st.config_reg = wr_byte;
                  if (wr_byte[SSC_CFG_SOFT_RESET]) begin
                    next_st.config_reg = SSC_RST_CONFIG;
                    next_st.user_spi_config = SSC_RST_USER_SPI;
                    next_st.clock_control_0 = SSC_RST_CLK0;
                    next_st.clock_control_1 = SSC_RST_CLK1;
                    next_st.clock_control_2 = SSC_RST_CLK2;
                  end
                end
                SSC_OFS_USER_SPI: next_st.user_spi_config = wr_byte;
                SSC_OFS_CLK0: next_st.clock_control_0 = wr_byte;
                SSC_OFS_CLK1: next_st.clock_control_1 = wr_byte;
                SSC_OFS_CLK2: next_st.clock_control_2 = wr_byte;
                default: next_st.addr = step_addr;
              endcase
            end
          end
        end
      endcase
    end else if (sclk_fall && st.phase == SSC_DATA && st.rd) begin
      // Read data moves on the falling edge so the host samples it stable on the rising one
      next_st.sdo = st.rd_shift[7];
      next_st.rd_shift = {st.rd_shift[6:0], 1'b0};
      next_st.sdo_oe_n = 1'b0;
    end

    // SYSREF event: rising edge of the delayed level, only while processing is on
    next_st.aligned_q = sr_if.aligned;
    next_st.sysref_event = sr_if.aligned && !st.aligned_q && st.clock_control_0[SSC_CK0_PROC_ON];

    // Sample LSB carries SYSREF when marking is live
    next_st.sample_out = sample_in;
    if (marker_live) begin
      next_st.sample_out[0] = sr_if.aligned;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= SSC_RESET_STATE;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // SYSREF alignment path
  // ----------------------------------------
  // Receiver off forces a steady low, so a later enable cannot fake an edge from stale taps
  assign sr_if.raw = st.clock_control_0[SSC_CK0_RECV_ON]
    & (sysref_in ^ st.clock_control_1[SSC_CK1_FLIP]);
  assign sr_if.fine_window = st.clock_control_0[SSC_CK0_FINE];
  assign sr_if.delay_choice = st.clock_control_0[SSC_CK0_SEL_HI:SSC_CK0_SEL_LO];

  ssc_sysref_delay #(
    .DEPTH(DELAY_DEPTH)
  ) u_delay (
    .clk(clk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .sr(sr_if.line)
  );

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign spi_sdo = st.sdo;
  assign spi_sdo_oe_n = st.sdo_oe_n;
  assign sysref_event = st.sysref_event;
  assign sample_out = st.sample_out;
  assign sysref_processor_on = st.clock_control_0[SSC_CK0_PROC_ON];
  assign sysref_receiver_on = st.clock_control_0[SSC_CK0_RECV_ON];
  assign sysref_fine_window = st.clock_control_0[SSC_CK0_FINE];
  assign sysref_delay_choice = st.clock_control_0[SSC_CK0_SEL_HI:SSC_CK0_SEL_LO];
  assign sysref_marker_inject = st.clock_control_1[SSC_CK1_MARKER];
  assign device_clock_pecl_mode = st.clock_control_1[SSC_CK1_DEVCLK_PECL];
  assign sysref_pecl_mode = st.clock_control_1[SSC_CK1_SYSREF_PECL];
  assign sysref_polarity_flip = st.clock_control_1[SSC_CK1_FLIP];
  assign supply_noise_suppress = st.clock_control_2[SSC_CK2_NOISE];
  assign sampling_clock_delay = st.clock_control_2[SSC_CK2_DEL_HI:SSC_CK2_DEL_LO];
  assign clock_feedback_gain = st.clock_control_2[SSC_CK2_FB_GAIN];

endmodule // ssc_cfg_regs

// ===== verif/ssc_cfg_regs_sva.sv
// Port checker for the configuration register bank.
// Assumes clk_en is held high by the bench.
`timescale 1ns/1ps
module ssc_cfg_regs_sva
  import ssc_pkg::*;
#(
  parameter int SAMPLE_W = SSC_SAMPLE_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Serial and SYSREF
  input wire logic spi_cs_n,
  input wire logic sysref_in,
  input wire logic sysref_event,
  // Samples
  input wire logic sample_marker_on,
  input wire logic decimation_bypass,
  input wire logic [SAMPLE_W-1:0] sample_in,
  input wire logic [SAMPLE_W-1:0] sample_out,
  // Configuration levels
  input wire logic sysref_processor_on,
  input wire logic sysref_receiver_on,
  input wire logic sysref_marker_inject,
  input wire logic sysref_polarity_flip,
  input wire logic clock_feedback_gain,
  input wire logic [SSC_TAP_W-1:0] sysref_delay_choice,
  input wire logic [1:0] sampling_clock_delay
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Tap zero only: longer taps would let old edges through after a change
  logic arm;
  assign arm = sysref_receiver_on && sysref_processor_on && sysref_delay_choice == 4'h0;
  property p_proc_gate;
    !sysref_processor_on [*3] |-> !sysref_event;
  endproperty
  a_proc_gate: assert property (p_proc_gate) else $error("event with processor off");
  property p_pulse;
    sysref_event |=> !sysref_event;
  endproperty
  a_pulse: assert property (p_pulse) else $error("event longer than one cycle");
  property p_recv_off;
    (!sysref_receiver_on && sysref_delay_choice == 4'h0) [*6] |-> !sysref_event;
  endproperty
  a_recv_off: assert property (p_recv_off) else $error("event with receiver off");
  property p_rise_evt;
    (arm && !sysref_polarity_flip && !sysref_in) [*3] ##1 (arm && !sysref_polarity_flip && sysref_in) [*3]
      |-> ##[0:3] sysref_event;
  endproperty
  a_rise_evt: assert property (p_rise_evt) else $error("no event on rising input");
  property p_fall_evt;
    (arm && sysref_polarity_flip && sysref_in) [*3] ##1 (arm && sysref_polarity_flip && !sysref_in) [*3]
      |-> ##[0:3] sysref_event;
  endproperty
  a_fall_evt: assert property (p_fall_evt) else $error("no event on inverted edge");
  property p_reset_val;
    $rose(arst_n) |-> sampling_clock_delay == 2'h1 && clock_feedback_gain && sysref_delay_choice == 4'h0;
  endproperty
  a_reset_val: assert property (p_reset_val) else $error("bad reset level");
  property p_cfg_hold;
    spi_cs_n && $past(spi_cs_n) |-> $stable({sysref_processor_on, sysref_receiver_on, sysref_marker_inject,
      sysref_polarity_flip, clock_feedback_gain, sysref_delay_choice, sampling_clock_delay});
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("config changed while idle");
  property p_sample_pass;
    $past(arst_n) && !$past(sysref_marker_inject && sample_marker_on && decimation_bypass)
      |-> sample_out == $past(sample_in);
  endproperty
  a_sample_pass: assert property (p_sample_pass) else $error("sample altered");
  property p_marker;
    (sysref_marker_inject && sample_marker_on && decimation_bypass && sysref_receiver_on
      && !sysref_polarity_flip && sysref_delay_choice == 4'h0 && sysref_in) [*6] |-> sample_out[0];
  endproperty
  a_marker: assert property (p_marker) else $error("marker bit missing");
endmodule // ssc_cfg_regs_sva

bind ssc_cfg_regs ssc_cfg_regs_sva #(.SAMPLE_W(SAMPLE_W)) u_ssc_cfg_regs_sva (.clk, .arst_n, .spi_cs_n,
  .sysref_in, .sysref_event, .sample_marker_on, .decimation_bypass, .sample_in, .sample_out,
  .sysref_processor_on, .sysref_receiver_on, .sysref_marker_inject, .sysref_polarity_flip,
  .clock_feedback_gain, .sysref_delay_choice, .sampling_clock_delay);

// ===== verif/ssc_spi_host.sv
// Serial host model that frames register accesses.
// Assumes three clk cycles per sclk half period suit the bank.
`timescale 1ns/1ps
module ssc_spi_host (
  // Clock
  input wire logic clk,
  // Serial port
  output logic spi_cs_n,
  output logic spi_sclk,
  input wire logic spi_sdo,
  output logic spi_sdi
);
  initial begin
    spi_cs_n = 1'b1;
    spi_sclk = 1'b0;
    spi_sdi = 1'b0;
  end
  // Instruction then n bytes; sclk stands low between frames
  task automatic frame(input logic rd, input logic [14:0] adr, input int n, input logic [31:0] wd,
                       output logic [31:0] rq);
    logic [47:0] sh;
    sh = {rd, adr, wd};
    rq = '0;
    spi_cs_n <= 1'b0;
    for (int i = 0; i < 16 + 8 * n; i++) begin
      spi_sclk <= 1'b0;
      spi_sdi <= sh[47 - i];
      repeat (3) @(posedge clk);
      if (i >= 16) rq = {rq[30:0], spi_sdo};
      spi_sclk <= 1'b1;
      repeat (3) @(posedge clk);
    end
    // Clock parks low together with the deselect, so the bank sees no edge inside the frame
    spi_cs_n <= 1'b1;
    spi_sclk <= 1'b0;
    // Released line must not keep showing the last bit
    spi_sdi <= ~spi_sdi;
    repeat (3) @(posedge clk);
  endtask
endmodule // ssc_spi_host

// ===== verif/tb_top.sv
// Self-checking bench for the configuration register bank.
// Assumes the host model and the bound port checker.
`timescale 1ns/1ps
module tb_top;
  import ssc_pkg::*;
  logic clk, arst_n, spi_cs_n, spi_sclk, spi_sdi, spi_sdo, spi_sdo_oe_n, sysref_in, sysref_event;
  logic sample_marker_on, decimation_bypass, sysref_processor_on, sysref_receiver_on, sysref_fine_window;
  logic sysref_marker_inject, device_clock_pecl_mode, sysref_pecl_mode, sysref_polarity_flip;
  logic supply_noise_suppress, clock_feedback_gain;
  logic [3:0] sysref_delay_choice;
  logic [1:0] sampling_clock_delay;
  logic [11:0] sample_in, sample_out;
  logic [31:0] rq;
  int err_count, checks, ev_cnt, oe_cnt;
  ssc_cfg_regs u_ssc_cfg_regs (.clk, .arst_n, .clk_en(1'b1), .spi_cs_n, .spi_sclk, .spi_sdi, .spi_sdo,
    .spi_sdo_oe_n, .sysref_in, .sysref_event, .sample_marker_on, .decimation_bypass, .sample_in, .sample_out,
    .sysref_processor_on, .sysref_receiver_on, .sysref_fine_window, .sysref_delay_choice, .sysref_marker_inject,
    .device_clock_pecl_mode, .sysref_pecl_mode, .sysref_polarity_flip, .supply_noise_suppress,
    .sampling_clock_delay, .clock_feedback_gain);
  ssc_spi_host u_ssc_spi_host (.clk, .spi_cs_n, .spi_sclk, .spi_sdo, .spi_sdi);
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // A write never turns the read driver on
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    int o0;
    o0 = oe_cnt;
    u_ssc_spi_host.frame(1'b0, a, 1, {d, 24'h000000}, rq);
    chk(32'(oe_cnt - o0), 32'h0);
  endtask
  task automatic rd(input logic [14:0] a, input int n, input logic [31:0] exp);
    u_ssc_spi_host.frame(1'b1, a, n, 32'h00000000, rq);
    chk(rq, exp);
  endtask
  // Tap zero settles well inside twelve cycles
  task automatic sr(input logic lv, input int exp);
    int e0;
    e0 = ev_cnt;
    sysref_in <= lv;
    repeat (12) @(posedge clk);
    chk(32'(ev_cnt - e0), 32'(exp));
  endtask
  task automatic print_verdict();
    if (err_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Clock, watchdog, sequence
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) if (sysref_event === 1'b1) ev_cnt++;
  always @(posedge clk) if (spi_sdo_oe_n === 1'b0) oe_cnt++;
  initial begin
    repeat (100000) @(posedge clk);
    err_count++;
    print_verdict();
  end
  initial begin
    arst_n = 1'b0;
    sysref_in = 1'b0;
    sample_marker_on = 1'b0;
    decimation_bypass = 1'b0;
    sample_in = 12'h000;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rd(SSC_OFS_CONFIG, 1, 32'h30);
    chk({spi_sdo_oe_n, oe_cnt != 0}, 2'h3);
    rd(SSC_OFS_USER_SPI, 1, 32'h00);
    rd(SSC_OFS_CLK0, 1, 32'h00);
    rd(SSC_OFS_CLK1, 1, 32'h00);
    rd(SSC_OFS_CLK2, 1, 32'h11);
    wr(SSC_OFS_CLK1, 8'hFF);
    rd(SSC_OFS_CLK1, 1, 32'hFF);
    chk({sysref_marker_inject, device_clock_pecl_mode, sysref_pecl_mode, sysref_polarity_flip}, 4'hF);
    wr(SSC_OFS_CLK2, 8'hE6);
    rd(SSC_OFS_CLK2, 1, 32'hE6);
    chk({clock_feedback_gain, supply_noise_suppress, sampling_clock_delay}, 4'h6);
    wr(SSC_OFS_CLK0, 8'hA0);
    wr(SSC_OFS_CLK0, 8'hF0);
    rd(SSC_OFS_CLK0, 1, 32'hF0);
    chk({sysref_processor_on, sysref_receiver_on, sysref_fine_window, sysref_delay_choice}, 7'h70);
    wr(15'h0011, 8'hAA);
    rd(15'h0011, 1, 32'h00);
    sr(1'b1, 0);
    sr(1'b0, 1);
    wr(SSC_OFS_CLK1, 8'h08);
    sr(1'b1, 1);
    sample_in <= 12'hABC;
    sample_marker_on <= 1'b1;
    decimation_bypass <= 1'b1;
    repeat (8) @(posedge clk);
    chk(sample_out, 12'hABD);
    decimation_bypass <= 1'b0;
    repeat (2) @(posedge clk);
    chk(sample_out, 12'hABC);
    sr(1'b0, 0);
    wr(SSC_OFS_CLK0, 8'h20);
    sr(1'b1, 0);
    sr(1'b0, 0);
    u_ssc_spi_host.frame(1'b0, SSC_OFS_CLK0, 3, 32'h21091700, rq);
    rd(SSC_OFS_CLK0, 3, 32'h00210917);
    wr(SSC_OFS_CONFIG, 8'h00);
    u_ssc_spi_host.frame(1'b0, SSC_OFS_CLK2, 2, 32'h11020000, rq);
    rd(SSC_OFS_CLK2, 2, 32'h00001102);
    wr(SSC_OFS_CONFIG, 8'h30);
    wr(SSC_OFS_USER_SPI, 8'h01);
    u_ssc_spi_host.frame(1'b0, SSC_OFS_CLK1, 3, 32'h0A0B0C00, rq);
    rd(SSC_OFS_CLK1, 2, 32'h00000C0C);
    rd(SSC_OFS_CLK0, 1, 32'h21);
    rd(SSC_OFS_CLK2, 1, 32'h11);
    wr(SSC_OFS_USER_SPI, 8'h00);
    wr(SSC_OFS_CONFIG, 8'hB0);
    rd(SSC_OFS_CLK0, 1, 32'h00);
    print_verdict();
  end
endmodule // tb_top
